// >>> rtl/packer_pkg.sv
package packer_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned CONV_NUM = 16;
  localparam int unsigned LANE_NUM = 8;
  localparam int unsigned SLOT_MAX = 8;
  localparam int unsigned FRAME_W = SLOT_MAX * SAMPLE_W;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] FCNT_OFS = 8'h08;
  localparam logic [31:0] CTRL_RST = 32'h0000005A;

  // control field positions
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_CPL_LSB = 1;
  localparam int unsigned CTRL_EN_BIT = 3;
  localparam int unsigned CTRL_RES_LSB = 4;
  localparam int unsigned CTRL_WID_LSB = 6;

  // status field positions
  localparam int unsigned STAT_L_LSB = 0;
  localparam int unsigned STAT_ERR_BIT = 4;
  localparam int unsigned STAT_F_LSB = 8;
  localparam int unsigned STAT_NP_LSB = 16;
  localparam int unsigned STAT_PD_LSB = 24;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // word widths and lane geometry
  // ------------------------------------------------------------
  localparam logic [4:0] BITS_BASE = 5'h0A;
  localparam logic [4:0] NP_PAIR_SHORT = 5'h0C;
  localparam logic [4:0] NP_PAIR_LONG = 5'h10;
  localparam logic [4:0] NP_SINGLE = 5'h10;
  localparam logic [3:0] CPL_EIGHT = 4'h8;
  localparam logic [3:0] CPL_FOUR = 4'h4;
  localparam logic [3:0] CPL_TWO = 4'h2;
  localparam logic [3:0] LANES_FOR_8 = 4'h2;
  localparam logic [3:0] LANES_FOR_4 = 4'h4;
  localparam logic [3:0] LANES_FOR_2 = 4'h8;
  localparam logic [7:0] PD_MASK_8 = 8'hEE;
  localparam logic [7:0] PD_MASK_4 = 8'hAA;
  localparam logic [7:0] PD_MASK_2 = 8'h00;
  localparam logic [7:0] PD_MASK_ALL = 8'hFF;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic {
    PACK_NORMAL = 1'b0,
    PACK_SINGLE = 1'b1
  } pack_mode_t;

  typedef enum logic [1:0] {
    CPL_2 = 2'b00,
    CPL_4 = 2'b01,
    CPL_8 = 2'b10
  } conv_per_lane_t;

  typedef struct packed {
    logic [1:0] serial_word_width;
    logic [1:0] sample_resolution;
    logic enable;
    conv_per_lane_t converters_on_lane;
    pack_mode_t single_sample_octet_pair_mode;
  } cfg_t;

  typedef struct packed {
    logic [3:0] lanes;
    logic [4:0] octets;
    logic [4:0] nprime;
    logic [3:0] per_lane;
    logic [4:0] resolution_bits;
    logic [4:0] transport_word_bits;
    logic [7:0] lane_pd;
    logic cfg_err;
  } geom_t;

  typedef struct packed {
    logic [CONV_NUM-1:0][SAMPLE_W-1:0] conv;
  } sample_frame_t;

endpackage : packer_pkg

// >>> rtl/mode_decode.sv
`timescale 1ns/1ns
`default_nettype none
module mode_decode
  import packer_pkg::*;
(
  // settings in
  input wire packer_pkg::cfg_t cfg,
  // derived geometry out
  output packer_pkg::geom_t geom
);

  // ------------------------------------------------------------
  // geometry from settings
  // ------------------------------------------------------------
  logic [4:0] wbits;
  logic [4:0] rbits;
  logic [4:0] slot;
  logic [8:0] prod;
  logic [3:0] per_lane;
  logic [3:0] lanes;
  logic [7:0] lane_pd;

  // widths are 10 + 2*code
  assign wbits = BITS_BASE + {2'b00, cfg.serial_word_width, 1'b0};
  assign rbits = BITS_BASE + {2'b00, cfg.sample_resolution, 1'b0};

  // lane count and idle lanes follow converters per lane
  always_comb
  begin
    case (cfg.converters_on_lane)
      CPL_8:
      begin
        per_lane = CPL_EIGHT;
        lanes = LANES_FOR_8;
        lane_pd = PD_MASK_8;
      end
      CPL_4:
      begin
        per_lane = CPL_FOUR;
        lanes = LANES_FOR_4;
        lane_pd = PD_MASK_4;
      end
      default:
      begin
        per_lane = CPL_TWO;
        lanes = LANES_FOR_2;
        lane_pd = PD_MASK_2;
      end
    endcase
  end

  // slot width per sample: dense, nibble-rounded or octet pair
  always_comb
  begin
    if (cfg.single_sample_octet_pair_mode == PACK_SINGLE)
      slot = NP_SINGLE;
    else if (cfg.converters_on_lane == CPL_8 || cfg.converters_on_lane == CPL_4)
      slot = wbits;
    else if (wbits <= NP_PAIR_SHORT)
      slot = NP_PAIR_SHORT;
    else
      slot = NP_PAIR_LONG;
  end

  // octets per frame = converters * slot / 8
  assign prod = 9'(per_lane) * 9'(slot);

  // one driver for the whole geometry word
  assign geom = '{lanes: lanes, octets: prod[7:3], nprime: slot, per_lane: per_lane,
    resolution_bits: rbits, transport_word_bits: wbits, lane_pd: lane_pd, cfg_err: (wbits < rbits)};

endmodule : mode_decode
`default_nettype wire

// >>> rtl/lane_packer.sv
`timescale 1ns/1ns
`default_nettype none
module lane_packer
  import packer_pkg::*;
#(
  parameter int unsigned SLOTS = 8
)
(
  // samples of this lane, first converter in slot 0
  input wire logic [SLOTS-1:0][SAMPLE_W-1:0] samples,
  // geometry
  input wire logic [3:0] used_slots,
  input wire logic [4:0] resolution_bits,
  input wire logic [4:0] slot_bits,
  // packed frame, octet 1 in the top byte
  output logic [SLOTS*SAMPLE_W-1:0] frame
);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  if (SLOTS < 1 || SLOTS > 15)
  begin : g_bad_slots
    $error("lane_packer: SLOTS out of range");
  end

  // ------------------------------------------------------------
  // packing: each word left-justified, shifted to its slot
  // ------------------------------------------------------------
  always_comb
  begin
    logic [SAMPLE_W-1:0] word;
    logic [SLOTS*SAMPLE_W-1:0] wide;
    logic [4:0] lsh;
    word = '0;
    wide = '0;
    lsh = 5'(SAMPLE_W) - resolution_bits;
    frame = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (i < used_slots)
      begin
        // zeros below the sample fill the word and slot tail
        word = samples[i] << lsh;
        wide = {word, {(SLOTS-1)*SAMPLE_W{1'b0}}};
        frame = frame | (wide >> (i * slot_bits));
      end
    end
  end

endmodule : lane_packer
`default_nettype wire

// >>> rtl/jesd_sample_packer.sv
`timescale 1ns/1ns
`default_nettype none
module jesd_sample_packer
  import packer_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned CONV_CNT = 16,
  parameter int unsigned LANE_CNT = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // converter samples, one per input slot
  input wire logic sample_valid,
  input wire packer_pkg::sample_frame_t sample_in,
  // lane frames
  output logic frame_valid,
  output logic [LANE_CNT-1:0][FRAME_W-1:0] lane_frame,
  output logic [4:0] frame_octets,
  output logic [3:0] lane_count,
  output logic [LANE_CNT-1:0] lane_power_down
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (CONV_CNT != CONV_NUM || LANE_CNT != LANE_NUM || ADDR_W < 8)
  begin : g_bad_params
    $error("jesd_sample_packer: unsupported parameter values");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [31:0] ctrl_r;
  cfg_t cfg;
  geom_t geom;
  logic [31:0] frame_cnt_r;
  logic aw_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_got_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic ctrl_wr;
  logic fcnt_wr;
  logic wr_hit;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic frame_go;
  logic frame_valid_r;
  logic [LANE_CNT-1:0][FRAME_W-1:0] lane_frame_r;
  logic [LANE_CNT-1:0][FRAME_W-1:0] packed_w;
  logic [4:0] frame_octets_r;
  logic [3:0] lane_count_r;
  logic [LANE_CNT-1:0] lane_pd_r;
  logic [LANE_CNT-1:0] lane_pd_w;

  // ------------------------------------------------------------
  // settings and geometry
  // ------------------------------------------------------------

  // low byte of the control word carries all settings
  assign cfg = cfg_t'(ctrl_r[7:0]);

  mode_decode u_mode_decode (
    .cfg(cfg),
    .geom(geom)
  );

  // idle lanes, or everything while packing is disabled
  assign lane_pd_w = cfg.enable ? geom.lane_pd : PD_MASK_ALL;

  // ------------------------------------------------------------
  // write path: address and data in either order
  // ------------------------------------------------------------

  // accept each channel once per write, none while a response waits
  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign wr_fire = (aw_got_r || aw_take) && (w_got_r || w_take);

  // take held values when a channel came earlier
  assign wr_addr = aw_got_r ? aw_addr_r : awaddr;
  assign wr_data = w_got_r ? w_data_r : wdata;
  assign wr_strb = w_got_r ? w_strb_r : wstrb;
  assign wr_ofs = {wr_addr[7:2], 2'b00};

  // decode of the write target
  assign ctrl_wr = wr_fire && (wr_ofs == CTRL_OFS) && wr_strb[0];
  assign fcnt_wr = wr_fire && (wr_ofs == FCNT_OFS) && (wr_strb != 4'h0);
  assign wr_hit = (wr_ofs == CTRL_OFS) || (wr_ofs == FCNT_OFS) || (wr_ofs == STAT_OFS);

  // write address hold
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (wr_fire)
      aw_got_r <= 1'b0;
    else if (aw_take)
    begin
      aw_got_r <= 1'b1;
      aw_addr_r <= awaddr;
    end
  end

  // write data hold
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else if (wr_fire)
      w_got_r <= 1'b0;
    else if (w_take)
    begin
      w_got_r <= 1'b1;
      w_data_r <= wdata;
      w_strb_r <= wstrb;
    end
  end

  // write response, one cycle after both channels are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid_r <= 1'b0;
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // control register, settings byte only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= CTRL_RST;
    else if (ctrl_wr)
      ctrl_r <= {24'h000000, wr_data[7:0]};
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------

  // status word: geometry and lane power state
  always_comb
  begin
    stat_word = '0;
    stat_word[STAT_L_LSB +: 4] = geom.lanes;
    stat_word[STAT_ERR_BIT] = geom.cfg_err;
    stat_word[STAT_F_LSB +: 5] = geom.octets;
    stat_word[STAT_NP_LSB +: 5] = geom.nprime;
    stat_word[STAT_PD_LSB +: 8] = lane_pd_w;
  end

  // register select for reads
  assign rd_ofs = {araddr[7:2], 2'b00};

  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (rd_ofs)
      CTRL_OFS: rd_word = ctrl_r;
      STAT_OFS: rd_word = stat_word;
      FCNT_OFS: rd_word = frame_cnt_r;
      default: rd_hit = 1'b0;
    endcase
  end

  assign arready = !rvalid_r;
  assign ar_take = arvalid && arready;

  // read data held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ------------------------------------------------------------
  // lane packing
  // ------------------------------------------------------------

  // lane k starts at converter 2k, same layout on every lane
  for (genvar l = 0; l < LANE_NUM; l++)
  begin : g_lane
    logic [SLOT_MAX-1:0][SAMPLE_W-1:0] lane_samples;
    for (genvar i = 0; i < SLOT_MAX; i++)
    begin : g_slot
      if (2 * l + i < CONV_NUM)
      begin : g_in
        assign lane_samples[i] = sample_in.conv[2*l+i];
      end
      else
      begin : g_none
        assign lane_samples[i] = '0;
      end
    end
    lane_packer #(
      .SLOTS(SLOT_MAX)
    ) u_lane_packer (
      .samples(lane_samples),
      .used_slots(geom.per_lane),
      .resolution_bits(geom.resolution_bits),
      .slot_bits(geom.nprime),
      .frame(packed_w[l])
    );
  end

  // frames go out only with a sane setting and packing enabled
  assign frame_go = sample_valid && cfg.enable && !geom.cfg_err;

  // lane frames, powered-down lanes loaded with zero on each frame, all held otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lane_frame_r <= '0;
    else if (frame_go)
    begin
      for (int l = 0; l < LANE_NUM; l++)
        lane_frame_r[l] <= lane_pd_w[l] ? '0 : packed_w[l];
    end
  end

  // one-cycle strobe per packed frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      frame_valid_r <= 1'b0;
    else
      frame_valid_r <= frame_go;
  end

  // geometry seen by the link side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frame_octets_r <= '0;
      lane_count_r <= '0;
      lane_pd_r <= PD_MASK_ALL;
    end
    else
    begin
      frame_octets_r <= geom.octets;
      lane_count_r <= geom.lanes;
      lane_pd_r <= lane_pd_w;
    end
  end

  // frame counter, a frame in the clearing cycle still counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      frame_cnt_r <= '0;
    else if (fcnt_wr)
      frame_cnt_r <= frame_go ? 32'h00000001 : 32'h00000000;
    else if (frame_go)
      frame_cnt_r <= frame_cnt_r + 32'h00000001;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign frame_valid = frame_valid_r;
  assign lane_frame = lane_frame_r;
  assign frame_octets = frame_octets_r;
  assign lane_count = lane_count_r;
  assign lane_power_down = lane_pd_r;

endmodule : jesd_sample_packer
`default_nettype wire

// >>> testbench/jesd_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
module jesd_rx_model
  import packer_pkg::*;
#(
  parameter int unsigned LANE_CNT = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frames from the packer
  input wire logic frame_valid,
  input wire logic [LANE_CNT-1:0][FRAME_W-1:0] lane_frame,
  // captured frames
  output logic [15:0] rx_cnt,
  output logic [LANE_CNT-1:0][FRAME_W-1:0] rx_frame
);
  // takes every octet as sample data, nothing stripped as control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_cnt <= 16'h0000;
      rx_frame <= '0;
    end
    else if (frame_valid)
    begin
      rx_cnt <= rx_cnt + 16'h0001;
      rx_frame <= lane_frame;
    end
  end
endmodule : jesd_rx_model
`default_nettype wire

// >>> testbench/jesd_sample_packer_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module jesd_sample_packer_checker
  import packer_pkg::*;
#(
  parameter int unsigned LANE_CNT = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // samples and frames
  input wire logic sample_valid,
  input wire logic frame_valid,
  input wire logic [LANE_CNT-1:0][FRAME_W-1:0] lane_frame,
  input wire logic [4:0] frame_octets,
  input wire logic [3:0] lane_count,
  input wire logic [7:0] lane_power_down
);
  logic dead_nz;
  logic tail_nz;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // flags data on powered-down lanes and octets past the frame end
  always_comb
  begin
    dead_nz = 1'b0;
    tail_nz = 1'b0;
    for (int l = 0; l < LANE_CNT; l++)
    begin
      if (lane_power_down[l] && |lane_frame[l]) dead_nz = 1'b1;
      if (|(lane_frame[l] << (8 * frame_octets))) tail_nz = 1'b1;
    end
  end
  AST_PD_UNUSED: assert property (frame_valid |-> !dead_nz)
    else $error("data on a powered-down lane");
  AST_TAIL_ONLY: assert property (frame_valid |-> !tail_nz)
    else $error("data beyond the frame octets");
  AST_LANES_2: assert property (frame_valid && lane_count == 4'h2 |->
    lane_power_down == PD_MASK_8 && frame_octets inside {10, 12, 14, 16}) else $error("two-lane geometry");
  AST_LANES_4: assert property (frame_valid && lane_count == 4'h4 |->
    lane_power_down == PD_MASK_4 && frame_octets inside {[5:8]}) else $error("four-lane geometry");
  AST_LANES_8: assert property (frame_valid && lane_count == 4'h8 |->
    lane_power_down == PD_MASK_2 && frame_octets inside {3, 4}) else $error("eight-lane geometry");
  AST_FV_CAUSE: assert property (frame_valid |-> $past(sample_valid))
    else $error("frame without samples");
  AST_FV_PULSE: assert property (frame_valid && !sample_valid |=> !frame_valid)
    else $error("frame pulse too long");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_BUSY: assert property ((bvalid |-> !awready && !wready) and (rvalid |-> !arready))
    else $error("request taken while answering");
  // main scenarios
  cover property (frame_valid && lane_count == 4'h2);
  cover property (frame_valid && lane_count == 4'h4);
  cover property (frame_valid && lane_count == 4'h8);
endmodule : jesd_sample_packer_checker
bind jesd_sample_packer jesd_sample_packer_checker #(.LANE_CNT(LANE_CNT)) i_checker (.aclk, .aresetn,
  .awready, .wready, .bvalid, .bready, .bresp, .arready, .rvalid, .rready, .rdata, .sample_valid,
  .frame_valid, .lane_frame, .frame_octets, .lane_count, .lane_power_down);
`default_nettype wire

// >>> testbench/tb_jesd_transport_sample_packer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_jesd_transport_sample_packer;
  import packer_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sample_valid = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0, lane_count;
  logic awready, wready, bvalid, arready, rvalid, frame_valid;
  logic [1:0] bresp, rresp, resp;
  sample_frame_t sample_in = '0, smp;
  logic [LANE_NUM-1:0][FRAME_W-1:0] lane_frame, rx_frame;
  logic [4:0] frame_octets;
  logic [7:0] lane_power_down, pd;
  logic [15:0] rx_cnt;
  int errors = 0, comparisons = 0, cycles = 0, nframes = 0, res, wid, k, p;
  int rt[6] = '{10, 10, 12, 14, 16, 12};
  int wt[6] = '{10, 12, 14, 16, 16, 12};
  // ----
  // design and far side
  // ----
  jesd_sample_packer i_jesd_sample_packer (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .sample_valid, .sample_in, .frame_valid, .lane_frame, .frame_octets, .lane_count, .lane_power_down);
  jesd_rx_model i_jesd_rx_model (.aclk, .aresetn, .frame_valid, .lane_frame, .rx_cnt, .rx_frame);
  always #25 aclk = ~aclk;
  // cuts a hang short
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    // lets an edge pass so the next call does not reassign in this step
    @(posedge aclk);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_reg
  // n samples back to back, then let the far side capture
  task automatic frame(input int n);
    sample_in <= smp;
    sample_valid <= 1'b1;
    repeat (n) @(posedge aclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : frame
  // left-justified words, slot width p, first converter on top
  function automatic logic [127:0] exp_lane(input int ln);
    logic [127:0] f;
    logic [15:0] w;
    f = '0;
    for (int i = 0; i < k; i++)
    begin
      w = (smp.conv[2 * ln + i] & 16'((17'h1 << res) - 1)) << (16 - res);
      f = f | ({w, 112'h0} >> (i * p));
    end
    return f;
  endfunction : exp_lane
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(CTRL_OFS); chk(rd, CTRL_RST);
    rd_reg(STAT_OFS); chk(rd, 32'hAA0C0604);
    rd_reg(8'h0C); chk({rd, resp}, {32'h0, RESP_SLVERR});
    wr(8'h10, 32'h0); chk(resp, RESP_SLVERR);
    // every lane setting and mode, with six width pairs
    for (int c = 0; c < 3; c++)
      for (int m = 0; m < 2; m++)
        for (int t = 0; t < 6; t++)
        begin
          res = rt[t];
          wid = wt[t];
          k = 2 << c;
          p = m ? 16 : (k == 2 ? (wid <= 12 ? 12 : 16) : wid);
          pd = k == 8 ? 8'hEE : (k == 4 ? 8'hAA : 8'h00);
          wr(CTRL_OFS, m | (c << 1) | 8 | (((res - 10) / 2) << 4) | (((wid - 10) / 2) << 6));
          rd_reg(STAT_OFS); chk(rd, (pd << 24) | (p << 16) | ((k * p / 8) << 8) | (16 / k));
          chk(lane_count, 16 / k);
          chk(frame_octets, k * p / 8);
          chk(lane_power_down, pd);
          for (int i = 0; i < 16; i++) smp.conv[i] = 16'hC3A5 ^ 16'(i * 'h1234 + t * 'h0F0F + c);
          frame(1);
          nframes++;
          chk(rx_cnt, nframes);
          for (int ln = 0; ln < 8; ln++)
            chk(rx_frame[ln], (2 * ln) % k == 0 ? exp_lane(ln) : '0);
        end
    wr(CTRL_OFS, 32'h3A);
    rd_reg(STAT_OFS); chk(rd[4], 1'b1);
    frame(1); chk(rx_cnt, nframes);
    wr(CTRL_OFS, 32'h52);
    rd_reg(STAT_OFS); chk(rd[31:24], PD_MASK_ALL);
    frame(1); chk(rx_cnt, nframes);
    rd_reg(FCNT_OFS); chk(rd, nframes);
    wr(FCNT_OFS, 32'h0);
    rd_reg(FCNT_OFS); chk(rd, 32'h0);
    wr(CTRL_OFS, 32'h5A);
    frame(2); chk(rx_cnt, nframes + 2);
    give_verdict();
  end
endmodule : tb_jesd_transport_sample_packer
`default_nettype wire
